// ===== bench/cbranch_assertions.sv
// Port-level checks of the compact branch decoder
module cbranch_assertions
    import cbranch_pkg::*;
#(
    parameter int         XLEN      = XLEN_DEFAULT,
    parameter logic [1:0] CMP_SHIFT = CMP_SHIFT_DEF,
    parameter logic [5:0] COP_POOL  = COP_POOL_DEFAULT
) (
    input wire logic            clk,
    input wire logic            rst,
    input wire logic            in_valid,
    input wire logic            in_ready,
    input wire logic [31:0]     instr,
    input wire logic [XLEN-1:0] pc,
    input wire logic [XLEN-1:0] hi_value,
    input wire logic [XLEN-1:0] lo_value,
    input wire logic            cop_req,
    input wire logic [4:0]      coproc_cond_index,
    input wire logic            cop_cond,
    input wire logic            out_valid,
    input wire logic            is_branch,
    input wire logic            taken,
    input wire logic [XLEN-1:0] target,
    input wire logic            squash_next,
    input wire logic            link_we,
    input wire logic [4:0]      link_index,
    input wire logic [XLEN-1:0] link_value,
    input wire logic            pass_illegal
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [5:0]      op;
    logic [4:0]      hf;
    logic [4:0]      lf;
    logic            acc;
    logic            lnk;
    logic [XLEN-1:0] off16;
    logic [XLEN-1:0] off21;
    assign op    = instr[31:26];
    assign hf    = instr[25:21];
    assign lf    = instr[20:16];
    assign acc   = in_valid && in_ready;
    assign off16 = {{(XLEN-16){instr[15]}}, instr[15:0]};
    assign off21 = {{(XLEN-21){instr[20]}}, instr[20:0]};
    // Link forms: nonzero high field, low field zero under groups a to d or equal under groups a and b
    assign lnk = hf != 5'h0 && (((op == OPCODE_GROUP_A || op == OPCODE_GROUP_B) && (lf == 5'h0 || lf == hf))
                 || ((op == OPCODE_GROUP_C || op == OPCODE_GROUP_D) && lf == 5'h0));
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    AST_COP_INDEX: assert property (acc && op == COP_POOL && hf[4:1] == COP_SUB_IF_TRUE[4:1]
        |=> cop_req && !in_ready && coproc_cond_index == $past(lf)) else $error("coprocessor request wrong");
    AST_COP_TAKEN: assert property (cop_req
        |=> out_valid && taken == ($past(cop_cond) ^ ($past(hf, 2) == COP_SUB_IF_FALSE)))
        else $error("cop branch wrong");
    AST_LINK_ALWAYS: assert property (acc && lnk
        |=> link_we && link_index == 5'h1f && link_value == $past(pc) + 4) else $error("link write missing");
    AST_LINK_TARGET: assert property (acc && lnk ##1 taken
        |-> target == $past(pc) + 4 + ($past(off16) << 1)) else $error("link target wrong");
    AST_SQUASH: assert property (out_valid |-> squash_next == taken) else $error("squash differs from taken");
    AST_SEQ_NEXT: assert property (acc ##1 out_valid && !taken
        |-> target == $past(pc) + 4) else $error("not taken target wrong");
    AST_LONG_ZERO: assert property (acc && hf != 5'h0 && op == OPCODE_GROUP_G
        |=> is_branch && taken == ($past(hi_value) == 0)
            && (!taken || target == $past(pc) + 4 + ($past(off21) << CMP_SHIFT)))
        else $error("long zero branch wrong");
    AST_REG_EQUAL: assert property (acc && op == OPCODE_GROUP_C && lf != 5'h0 && lf < hf
        |=> is_branch && taken == ($past(hi_value) == $past(lo_value))) else $error("equal branch wrong");
    AST_UNSIGNED: assert property (acc && op == OPCODE_GROUP_B && lf != 5'h0 && hf != 5'h0 && lf != hf
        |=> taken == ($past(lo_value) < $past(hi_value))) else $error("unsigned branch wrong");
    AST_ILLEGAL: assert property (acc && hf == 5'h0 && (op == OPCODE_GROUP_A || op == OPCODE_GROUP_G)
        |=> out_valid && pass_illegal && !is_branch) else $error("illegal pattern not passed on");
endmodule

// ===== bench/compact_branch_decode_eval_bench.sv
// Self-checking bench for the compact branch decoder
`define CHK(nm, got, exp) begin cmp_count++; if ((got) !== (exp)) begin failures++; \
    $display("unexpected %s: expected %h, seen %h", nm, exp, got); end end
module compact_branch_decode_eval_bench import cbranch_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic tk, lk, il, br; logic [31:0] tg, ln;} exp_t;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        in_valid = 1'b0;
    logic [31:0] instr = 32'h0;
    logic [31:0] pc = 32'h0;
    logic [31:0] hi_value = 32'h0;
    logic [31:0] lo_value = 32'h0;
    logic [31:0] cond_flags = 32'h8000_0001;
    logic [31:0] pcv = 32'h1000;
    logic        in_ready, cop_req, cop_cond, out_valid, is_branch, taken, squash_next, link_we, pass_illegal;
    logic [4:0]  coproc_cond_index, link_index;
    logic [31:0] target, link_value;
    int          failures = 0;
    int          cmp_count = 0;
    int          cycles = 0;
    exp_t        q[$];

    always #5 clk = ~clk;

    compact_branch_decode_eval u_dut (.clk(clk), .rst(rst), .in_valid(in_valid), .in_ready(in_ready),
        .instr(instr), .pc(pc), .hi_value(hi_value), .lo_value(lo_value), .cop_req(cop_req),
        .coproc_cond_index(coproc_cond_index), .cop_cond(cop_cond), .out_valid(out_valid), .is_branch(is_branch),
        .taken(taken), .target(target), .squash_next(squash_next), .link_we(link_we), .link_index(link_index),
        .link_value(link_value), .pass_illegal(pass_illegal));
    cop2_cond_model u_cop (.clk(clk), .rst(rst), .cop_req(cop_req), .coproc_cond_index(coproc_cond_index),
        .cond_flags(cond_flags), .cop_cond(cop_cond));

    task automatic complete_run();
        $display("comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Flags are {taken, link, illegal}; a shift of zero marks a non-branch
    task automatic put(input logic [5:0] op, input logic [4:0] h, l, input logic [15:0] f,
                       input logic [31:0] hv, lv, input logic [2:0] fl, input logic [1:0] sh);
        logic [31:0] o;
        o = (op == OPCODE_GROUP_G || op == OPCODE_GROUP_H) ? {{11{l[4]}}, l, f} : {{16{f[15]}}, f};
        q.push_back('{fl[2], fl[1], fl[0], sh != 2'h0, fl[2] ? pcv + 32'h4 + (o << sh) : pcv + 32'h4, pcv + 32'h4});
        in_valid <= 1'b1;
        instr    <= {op, h, l, f};
        pc       <= pcv;
        hi_value <= hv;
        lo_value <= lv;
        pcv = pcv + 32'h40;
    endtask

    task automatic chk();
        exp_t e;
        int   n;
        e = q.pop_front();
        n = 0;
        while (out_valid !== 1'b1 && n < 4) begin
            @(posedge clk);
            #1;
            n++;
        end
        `CHK("out_valid", out_valid, 1'b1)
        `CHK("taken", taken, e.tk)
        `CHK("target", target, e.tg)
        `CHK("squash_next", squash_next, e.tk)
        `CHK("link_we", link_we, e.lk)
        `CHK("is_branch", is_branch, e.br)
        `CHK("pass_illegal", pass_illegal, e.il)
        if (e.lk) `CHK("link_value", link_value, e.ln)
    endtask

    task automatic one(input logic [5:0] op, input logic [4:0] h, l, input logic [15:0] f,
                       input logic [31:0] hv, lv, input logic [2:0] fl, input logic [1:0] sh);
        @(posedge clk);
        put(op, h, l, f, hv, lv, fl, sh);
        @(posedge clk);
        in_valid <= 1'b0;
        #1;
        if (op == COP_POOL_DEFAULT) begin
            `CHK("cop_req", cop_req, 1'b1)
            `CHK("coproc_cond_index", coproc_cond_index, l)
        end
        chk();
    endtask

    task automatic t_link();
        one(OPCODE_GROUP_A, 5'h3, 5'h0, 16'hfff0, 32'h0, 32'h5, 3'b110, LINK_SHIFT);
        one(OPCODE_GROUP_A, 5'h3, 5'h3, 16'h0010, 32'hffff_ffff, 32'h0, 3'b010, LINK_SHIFT);
        one(OPCODE_GROUP_B, 5'h7, 5'h0, 16'h8000, 32'h1, 32'h0, 3'b110, LINK_SHIFT);
        one(OPCODE_GROUP_B, 5'h7, 5'h7, 16'h7fff, 32'h0, 32'h0, 3'b010, LINK_SHIFT);
        one(OPCODE_GROUP_C, 5'h9, 5'h0, 16'h0004, 32'h0, 32'h1, 3'b110, LINK_SHIFT);
        one(OPCODE_GROUP_D, 5'h9, 5'h0, 16'h0004, 32'h0, 32'h1, 3'b010, LINK_SHIFT);
    endtask

    task automatic t_regs();
        one(OPCODE_GROUP_C, 5'h8, 5'h2, 16'h0100, 32'h5, 32'h5, 3'b100, CMP_SHIFT_DEF);
        one(OPCODE_GROUP_D, 5'h8, 5'h2, 16'h0100, 32'h5, 32'h5, 3'b000, CMP_SHIFT_DEF);
        one(OPCODE_GROUP_F, 5'h1, 5'h2, 16'hffff, 32'h1, 32'hffff_fffe, 3'b100, CMP_SHIFT_DEF);
        one(OPCODE_GROUP_E, 5'h1, 5'h2, 16'hffff, 32'h1, 32'hffff_fffe, 3'b000, CMP_SHIFT_DEF);
        one(OPCODE_GROUP_B, 5'h1, 5'h2, 16'h0020, 32'h1, 32'hffff_fffe, 3'b000, CMP_SHIFT_DEF);
        one(OPCODE_GROUP_A, 5'h1, 5'h2, 16'h0020, 32'h1, 32'hffff_fffe, 3'b100, CMP_SHIFT_DEF);
        one(OPCODE_GROUP_F, 5'h2, 5'h1, 16'h0008, 32'h7, 32'h3, 3'b100, CMP_SHIFT_DEF);
        one(OPCODE_GROUP_C, 5'h2, 5'h8, 16'h0008, 32'h7, 32'h7, 3'b000, 2'h0);
    endtask

    task automatic t_zero();
        one(OPCODE_GROUP_E, 5'h4, 5'h0, 16'h0040, 32'h0, 32'h9, 3'b100, CMP_SHIFT_DEF);
        one(OPCODE_GROUP_E, 5'h4, 5'h4, 16'h0040, 32'h8000_0000, 32'h9, 3'b000, CMP_SHIFT_DEF);
        one(OPCODE_GROUP_F, 5'h4, 5'h0, 16'h0040, 32'h0, 32'h9, 3'b000, CMP_SHIFT_DEF);
        one(OPCODE_GROUP_F, 5'h4, 5'h4, 16'h0040, 32'h8000_0000, 32'h9, 3'b100, CMP_SHIFT_DEF);
        one(OPCODE_GROUP_G, 5'h4, 5'h10, 16'h0000, 32'h0, 32'h9, 3'b100, CMP_SHIFT_DEF);
        one(OPCODE_GROUP_H, 5'h4, 5'h0f, 16'hffff, 32'h0, 32'h9, 3'b000, CMP_SHIFT_DEF);
    endtask

    task automatic t_odd();
        one(OPCODE_GROUP_A, 5'h0, 5'h3, 16'h0004, 32'h0, 32'h0, 3'b001, 2'h0);
        one(OPCODE_GROUP_E, 5'h0, 5'h3, 16'h0004, 32'h0, 32'h0, 3'b001, 2'h0);
        one(OPCODE_GROUP_G, 5'h0, 5'h0, 16'h0004, 32'h0, 32'h0, 3'b001, 2'h0);
        one(6'h00, 5'h1, 5'h2, 16'h0004, 32'h0, 32'h0, 3'b000, 2'h0);
        one(COP_POOL_DEFAULT, COP_SUB_IF_TRUE, 5'h0, 16'hff80, 32'h0, 32'h0, 3'b100, COP_SHIFT);
        one(COP_POOL_DEFAULT, COP_SUB_IF_FALSE, 5'h1f, 16'h0080, 32'h0, 32'h0, 3'b000, COP_SHIFT);
        one(COP_POOL_DEFAULT, COP_SUB_IF_FALSE, 5'h2, 16'h0080, 32'h0, 32'h0, 3'b100, COP_SHIFT);
        // Branch followed at once by another branch, no gap
        @(posedge clk);
        put(OPCODE_GROUP_G, 5'h1, 5'h0, 16'h0008, 32'h0, 32'h0, 3'b100, CMP_SHIFT_DEF);
        @(posedge clk);
        put(OPCODE_GROUP_B, 5'h5, 5'h0, 16'h0002, 32'h1, 32'h0, 3'b110, LINK_SHIFT);
        #1;
        chk();
        @(posedge clk);
        in_valid <= 1'b0;
        #1;
        chk();
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 2000) begin
            failures++;
            complete_run();
        end
    end

    initial begin
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        #1;
        `CHK("link_index", link_index, LINK_REG_INDEX)
        `CHK("out_valid", out_valid, 1'b0)
        `CHK("in_ready", in_ready, 1'b1)
        t_link();
        t_regs();
        t_zero();
        t_odd();
        complete_run();
    end
endmodule

bind compact_branch_decode_eval cbranch_assertions #(.XLEN(XLEN), .CMP_SHIFT(CMP_SHIFT), .COP_POOL(COP_POOL)) u_chk (
    .clk(clk), .rst(rst), .in_valid(in_valid), .in_ready(in_ready), .instr(instr), .pc(pc), .hi_value(hi_value),
    .lo_value(lo_value), .cop_req(cop_req), .coproc_cond_index(coproc_cond_index), .cop_cond(cop_cond),
    .out_valid(out_valid), .is_branch(is_branch), .taken(taken), .target(target), .squash_next(squash_next),
    .link_we(link_we), .link_index(link_index), .link_value(link_value), .pass_illegal(pass_illegal));

// ===== bench/cop2_cond_model.sv
// Behavioural coprocessor condition source
module cop2_cond_model (
    input  wire logic        clk,
    input  wire logic        rst,
    input  wire logic        cop_req,
    input  wire logic [4:0]  coproc_cond_index,
    input  wire logic [31:0] cond_flags,
    output logic             cop_cond
);
    timeunit 1ns;
    timeprecision 1ps;
    logic junk_r;
    // Outside a request the line toggles, so a late sample never looks valid
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            junk_r <= 1'b0;
        end else begin
            junk_r <= ~junk_r;
        end
    end
    assign cop_cond = cop_req ? cond_flags[coproc_cond_index] : junk_r;
endmodule

// ===== inc/cbranch_pkg.sv
// Constants and types shared by the compact branch decoder and its helpers
package cbranch_pkg;

    // ------------------------------------------------------------
    // Primary opcodes
    // ------------------------------------------------------------
    localparam logic [5:0] OPCODE_GROUP_A = 6'h30;
    localparam logic [5:0] OPCODE_GROUP_B = 6'h38;
    localparam logic [5:0] OPCODE_GROUP_C = 6'h1d;
    localparam logic [5:0] OPCODE_GROUP_D = 6'h1f;
    localparam logic [5:0] OPCODE_GROUP_E = 6'h3d;
    localparam logic [5:0] OPCODE_GROUP_F = 6'h35;
    localparam logic [5:0] OPCODE_GROUP_G = 6'h20;
    localparam logic [5:0] OPCODE_GROUP_H = 6'h28;
    // Immediate-pool opcode for coprocessor branches, value arbitrary
    localparam logic [5:0] COP_POOL_DEFAULT = 6'h10;
    localparam logic [4:0] COP_SUB_IF_FALSE = 5'h0a;
    localparam logic [4:0] COP_SUB_IF_TRUE  = 5'h0b;

    // ------------------------------------------------------------
    // Field positions and widths
    // ------------------------------------------------------------
    localparam int OPCODE_LSB   = 26;
    localparam int FIELD_HI_LSB = 21;
    localparam int FIELD_LO_LSB = 16;
    localparam int SHORT_OFF_W  = 16;
    localparam int LONG_OFF_W   = 21;

    // ------------------------------------------------------------
    // Values
    // ------------------------------------------------------------
    localparam logic [4:0] LINK_REG_INDEX = 5'h1f;
    localparam int         INSTR_BYTES    = 4;
    localparam logic [1:0] LINK_SHIFT     = 2'h1;
    localparam logic [1:0] COP_SHIFT      = 2'h1;
    localparam logic [1:0] CMP_SHIFT_DEF  = 2'h2;
    localparam int         XLEN_DEFAULT   = 32;

    typedef enum logic [4:0] {
        K_NONE, K_LINK_LE, K_LINK_GE, K_LINK_GT, K_LINK_LT, K_LINK_EQ, K_LINK_NE,
        K_EQ, K_NE, K_SLT, K_SGE, K_ULT, K_UGE,
        K_LTZ, K_LEZ, K_GEZ, K_GTZ, K_EQZ, K_NEZ, K_COP_F, K_COP_T
    } kind_t;

    typedef enum logic {
        ST_IDLE,
        ST_COP_WAIT
    } state_t;

endpackage

// ===== verilog/compact_branch_decode_eval.sv
// Compact conditional branch decoder and evaluator
module compact_branch_decode_eval
    import cbranch_pkg::*;
#(
    parameter int         XLEN      = cbranch_pkg::XLEN_DEFAULT,
    parameter logic [1:0] CMP_SHIFT = cbranch_pkg::CMP_SHIFT_DEF,
    parameter logic [5:0] COP_POOL  = cbranch_pkg::COP_POOL_DEFAULT
) (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              in_valid,
    output logic                   in_ready,
    input  wire logic [31:0]       instr,
    input  wire logic [XLEN-1:0]   pc,
    input  wire logic [XLEN-1:0]   hi_value,
    input  wire logic [XLEN-1:0]   lo_value,
    output logic                   cop_req,
    output logic      [4:0]        coproc_cond_index,
    input  wire logic              cop_cond,
    output logic                   out_valid,
    output logic                   is_branch,
    output logic                   taken,
    output logic      [XLEN-1:0]   target,
    output logic                   squash_next,
    output logic                   link_we,
    output logic      [4:0]        link_index,
    output logic      [XLEN-1:0]   link_value,
    output logic                   pass_illegal
);
    import cbranch_pkg::*;

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        // Handshake and coprocessor round trip
        state_t            st;
        logic              in_ready;
        logic              cop_req;
        logic [4:0]        cop_idx;
        logic              cop_inv;
        logic [XLEN-1:0]   pend_target;
        logic [XLEN-1:0]   pend_seq;

        // Result: out_valid and link_we pulse, the rest held until the next one
        logic              out_valid;
        logic              is_branch;
        logic              taken;
        logic [XLEN-1:0]   target;
        logic              squash_next;
        logic              link_we;
        logic [4:0]        link_index;
        logic [XLEN-1:0]   link_value;
        logic              pass_illegal;
    } regs_t;

    regs_t s_r;
    regs_t s_nxt;

    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    // Full field decode: the primary opcode alone is never enough,
    // since several instructions share each group except g and h.
    function automatic kind_t decode(input logic [5:0] op,
                                     input logic [4:0] hi,
                                     input logic [4:0] lo,
                                     input logic [5:0] cop_pool);
        kind_t k;
        logic  hi_nz;
        logic  lo_nz;

        k     = K_NONE;
        hi_nz = (hi != 5'h00);
        lo_nz = (lo != 5'h00);
        // Group a/b: link le/gt, link ge/lt, unsigned ge/lt
        // Group c/d: link eq/ne, register equal/differ
        // Group e/f: le/gt zero, ge/lt zero, signed ge/lt
        // Group g/h: long equal and not-equal zero
        if (op == OPCODE_GROUP_A) begin
            if (hi_nz && !lo_nz) begin
                k = K_LINK_LE;
            end else if (hi_nz && lo == hi) begin
                k = K_LINK_GE;
            end else if (hi_nz && lo_nz) begin
                k = K_UGE;
            end
        end else if (op == OPCODE_GROUP_B) begin
            if (hi_nz && !lo_nz) begin
                k = K_LINK_GT;
            end else if (hi_nz && lo == hi) begin
                k = K_LINK_LT;
            end else if (hi_nz && lo_nz) begin
                k = K_ULT;
            end
        end else if (op == OPCODE_GROUP_C) begin
            if (hi_nz && !lo_nz) begin
                k = K_LINK_EQ;
            end else if (lo_nz && lo < hi) begin
                k = K_EQ;
            end
        end else if (op == OPCODE_GROUP_D) begin
            if (hi_nz && !lo_nz) begin
                k = K_LINK_NE;
            end else if (lo_nz && lo < hi) begin
                k = K_NE;
            end
        end else if (op == OPCODE_GROUP_E) begin
            if (hi_nz && !lo_nz) begin
                k = K_LEZ;
            end else if (hi_nz && lo == hi) begin
                k = K_GEZ;
            end else if (hi_nz && lo_nz) begin
                k = K_SGE;
            end
        end else if (op == OPCODE_GROUP_F) begin
            if (hi_nz && !lo_nz) begin
                k = K_GTZ;
            end else if (hi_nz && lo == hi) begin
                k = K_LTZ;
            end else if (hi_nz && lo_nz) begin
                k = K_SLT;
            end
        end else if (op == OPCODE_GROUP_G) begin
            if (hi_nz) begin
                k = K_EQZ;
            end
        end else if (op == OPCODE_GROUP_H) begin
            if (hi_nz) begin
                k = K_NEZ;
            end
        end else if (op == cop_pool) begin
            if (hi == COP_SUB_IF_FALSE) begin
                k = K_COP_F;
            end else if (hi == COP_SUB_IF_TRUE) begin
                k = K_COP_T;
            end
        end
        return k;
    endfunction

    // Groups c and d also carry the overflow branches, so an unmatched
    // pattern there belongs to another decoder and is not illegal here.
    function automatic logic strict_group(input logic [5:0] op);
        return (op == OPCODE_GROUP_A) || (op == OPCODE_GROUP_B) ||
               (op == OPCODE_GROUP_E) || (op == OPCODE_GROUP_F) ||
               (op == OPCODE_GROUP_G) || (op == OPCODE_GROUP_H);
    endfunction

    logic [5:0] op;
    logic [4:0] hi_field;
    logic [4:0] lo_field;
    kind_t      kind;

    assign op       = instr[31:OPCODE_LSB];
    assign hi_field = instr[FIELD_HI_LSB+4:FIELD_HI_LSB];
    assign lo_field = instr[FIELD_LO_LSB+4:FIELD_LO_LSB];
    assign kind     = decode(op, hi_field, lo_field, COP_POOL);

    // ------------------------------------------------------------
    // Operands
    // ------------------------------------------------------------
    logic rr_eq;
    logic rr_slt;
    logic rr_ult;
    logic hi_zero;
    logic hi_neg;

    // First source sits in the low field, second in the high field
    operand_compare #(.W(XLEN)) u_cmp (
        .a   (lo_value),
        .b   (hi_value),
        .eq  (rr_eq),
        .slt (rr_slt),
        .ult (rr_ult)
    );

    // Sign and zero tests for the single-register forms
    assign hi_zero = (hi_value == '0);
    assign hi_neg  = hi_value[XLEN-1];

    // ------------------------------------------------------------
    // Offset and target
    // ------------------------------------------------------------
    logic            long_off;
    logic [1:0]      shift;
    logic [XLEN-1:0] seq_pc;
    logic [XLEN-1:0] br_target;

    // One adder serves all forms; only width and shift vary
    assign long_off = (kind == K_EQZ) || (kind == K_NEZ);

    always_comb begin
        case (kind)
            K_LINK_LE, K_LINK_GE, K_LINK_GT,
            K_LINK_LT, K_LINK_EQ, K_LINK_NE: shift = LINK_SHIFT;
            K_COP_F, K_COP_T:                shift = COP_SHIFT;
            default:                         shift = CMP_SHIFT;
        endcase
    end

    target_calc #(.W(XLEN)) u_tgt (
        .pc        (pc),
        .off_field (instr[LONG_OFF_W-1:0]),
        .long_off  (long_off),
        .shift     (shift),
        .seq_pc    (seq_pc),
        .target    (br_target)
    );

    // ------------------------------------------------------------
    // Condition
    // ------------------------------------------------------------
    logic cond;
    logic is_link;

    always_comb begin
        case (kind)
            K_LINK_LE, K_LEZ: cond = hi_neg || hi_zero;
            K_LINK_GE, K_GEZ: cond = !hi_neg;
            K_LINK_GT, K_GTZ: cond = !hi_neg && !hi_zero;
            K_LINK_LT, K_LTZ: cond = hi_neg;
            K_LINK_EQ:        cond = hi_zero;
            K_LINK_NE:        cond = !hi_zero;
            K_EQ:             cond = rr_eq;
            K_NE:             cond = !rr_eq;
            // Swapped-operand aliases arrive already encoded as these
            K_SLT:            cond = rr_slt;
            K_SGE:            cond = !rr_slt;
            K_ULT:            cond = rr_ult;
            K_UGE:            cond = !rr_ult;
            K_EQZ:            cond = hi_zero;
            K_NEZ:            cond = !hi_zero;
            default:          cond = 1'b0;
        endcase
    end

    // Link forms write register 31 whether taken or not
    assign is_link = (kind == K_LINK_LE) || (kind == K_LINK_GE) ||
                     (kind == K_LINK_GT) || (kind == K_LINK_LT) ||
                     (kind == K_LINK_EQ) || (kind == K_LINK_NE);

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    logic accept;

    assign accept = in_valid && s_r.in_ready;

    always_comb begin
        logic cop_true;

        cop_true            = 1'b0;
        // Pulses drop unless set below; results hold
        s_nxt               = s_r;
        s_nxt.out_valid     = 1'b0;
        s_nxt.cop_req       = 1'b0;
        s_nxt.link_we       = 1'b0;
        s_nxt.link_index    = LINK_REG_INDEX;
        case (s_r.st)
            ST_IDLE: begin
                // No slot check: unless a coprocessor branch was just accepted, the next
                // instruction is taken on the very next edge, whatever it is.
                s_nxt.in_ready = 1'b1;
                if (accept) begin
                    if (kind == K_COP_F || kind == K_COP_T) begin
                        // The coprocessor answers while the request stands,
                        // so the stream pauses for one cycle.
                        s_nxt.st          = ST_COP_WAIT;
                        s_nxt.in_ready    = 1'b0;
                        s_nxt.cop_req     = 1'b1;
                        s_nxt.cop_idx     = hi_field == COP_SUB_IF_FALSE ?
                                            lo_field : lo_field;
                        s_nxt.cop_inv     = (kind == K_COP_F);
                        s_nxt.pend_target = br_target;
                        s_nxt.pend_seq    = seq_pc;
                    end else begin
                        // All other forms answer on the next edge
                        s_nxt.out_valid    = 1'b1;
                        s_nxt.is_branch    = (kind != K_NONE);
                        s_nxt.taken        = cond;
                        s_nxt.target       = cond ? br_target : seq_pc;
                        s_nxt.squash_next  = cond;
                        s_nxt.link_we      = is_link;
                        s_nxt.link_value   = seq_pc;
                        s_nxt.pass_illegal = (kind == K_NONE) &&
                                             strict_group(op);
                    end
                end
            end
            ST_COP_WAIT: begin
                // The answer is taken at the edge ending the request
                cop_true           = s_r.cop_inv ? !cop_cond : cop_cond;
                s_nxt.st           = ST_IDLE;
                s_nxt.in_ready     = 1'b1;
                s_nxt.out_valid    = 1'b1;
                s_nxt.is_branch    = 1'b1;
                s_nxt.taken        = cop_true;
                s_nxt.target       = cop_true ? s_r.pend_target : s_r.pend_seq;
                s_nxt.squash_next  = cop_true;
                // No link write: these forms do not link
                s_nxt.link_value   = s_r.pend_seq;
                s_nxt.pass_illegal = 1'b0;
            end
            default: begin
                s_nxt.st       = ST_IDLE;
                s_nxt.in_ready = 1'b1;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            // Link index is fixed, so it leaves reset at its value
            s_r            <= '0;
            s_r.st         <= ST_IDLE;
            s_r.link_index <= LINK_REG_INDEX;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    // Straight from the state register, no decode on the way out
    assign in_ready          = s_r.in_ready;
    assign cop_req           = s_r.cop_req;
    assign coproc_cond_index = s_r.cop_idx;
    assign out_valid         = s_r.out_valid;
    assign is_branch         = s_r.is_branch;
    assign taken             = s_r.taken;
    assign target            = s_r.target;
    assign squash_next       = s_r.squash_next;
    assign link_we           = s_r.link_we;
    assign link_index        = s_r.link_index;
    assign link_value        = s_r.link_value;
    assign pass_illegal      = s_r.pass_illegal;

endmodule

// ===== verilog/operand_compare.sv
// Equality, signed and unsigned ordering of two register values
module operand_compare #(
    parameter int W = 32
) (
    input  wire logic [W-1:0] a,
    input  wire logic [W-1:0] b,
    output logic              eq,
    output logic              slt,
    output logic              ult
);
    assign eq  = (a == b);
    assign slt = ($signed(a) < $signed(b));
    assign ult = (a < b);
endmodule

// ===== verilog/target_calc.sv
// Sequential address and PC-relative target from an offset field
module target_calc #(
    parameter int W = 32
) (
    input  wire logic [W-1:0]  pc,
    input  wire logic [20:0]   off_field,
    input  wire logic          long_off,
    input  wire logic [1:0]    shift,
    output logic      [W-1:0]  seq_pc,
    output logic      [W-1:0]  target
);
    import cbranch_pkg::*;
    logic [W-1:0] sext;

    always_comb begin
        if (long_off) begin
            sext = W'($signed(off_field));
        end else begin
            sext = W'($signed(off_field[SHORT_OFF_W-1:0]));
        end
    end

    assign seq_pc = pc + W'(INSTR_BYTES);
    assign target = seq_pc + (sext << shift);
endmodule
